// ---- network_setup_config.sv ----
// Network setup configuration register with its AHB-Lite slave and the logic it steers.
//
// The placing of the registers and the AHB-Lite register port were left to the implementer.
`default_nettype none
module network_setup_config
    import network_setup_pkg::*;
(
    // Clock and reset.
    input wire logic hclk,
    input wire logic hresetn,
    // AHB-Lite slave port.
    input wire logic hsel,
    input wire logic [7:0] haddr,
    input wire logic [1:0] htrans,
    input wire logic hwrite,
    input wire logic [2:0] hsize,
    input wire logic hready,
    input wire logic [31:0] hwdata,
    output logic hreadyout,
    output logic hresp,
    output logic [31:0] hrdata,
    // Pulse-one line driver.
    input wire logic backplane_mode,
    input wire logic pulse_one_level,
    output logic line_pulse_one_output,
    output logic line_pulse_one_oe_n,
    // Refusal events from the protocol engine.
    input wire logic refusal_detected,
    output logic excess_refusal_flag,
    // Receive filtering.
    input wire logic rx_packet_valid,
    input wire logic [7:0] rx_dest_id,
    output logic rx_accept,
    output logic ack_send,
    // Clock enables for the rate and arbitration logic.
    output logic data_rate_tick,
    output logic arb_clock_enable
);

    // Register state.
    logic [7:0] setup_q, setup_d;
    logic [7:0] node_id_q, node_id_d;
    logic [7:0] refusal_cnt_q, refusal_cnt_d;
    logic excess_q, excess_d;
    // Bus state.
    logic wr_pend_q, wr_pend_d;
    logic [7:0] wr_addr_q, wr_addr_d;
    logic [31:0] rdata_q, rdata_d;
    // Line, receive and clock state.
    logic pulse_out_q, pulse_out_d;
    logic pulse_oe_n_q, pulse_oe_n_d;
    logic accept_q, accept_d;
    logic ack_q, ack_d;
    logic [7:0] rate_cnt_q, rate_cnt_d;
    logic rate_tick_q, rate_tick_d;
    logic arb_en_q, arb_en_d;

    // Shared decode signals.
    logic addr_phase;
    logic status_clear;
    logic [7:0] threshold;
    logic refusal_hit;
    logic [7:0] divisor;

    // Divisor of the base clock for each data rate divider code. The codes that software
    // must not use fall back to the slowest rate, so the tick never stops.
    function automatic logic [7:0] rate_divisor(input logic [2:0] code);
        logic [7:0] div;
        div = 8'h80;
        case (code)
            3'h0: div = 8'h08;
            3'h1: div = 8'h10;
            3'h2: div = 8'h20;
            3'h3: div = 8'h40;
            3'h4: div = 8'h80;
            default: div = 8'h80;
        endcase
        return div;
    endfunction : rate_divisor

    // Counting stops at all ones, so a long run can never wrap back under a threshold.
    function automatic logic [7:0] sat_inc(input logic [7:0] value);
        return (value == REFUSAL_COUNT_MAX) ? value : value + 8'h01;
    endfunction : sat_inc

    // A transfer is taken only when selected, active and the bus is ready.
    assign addr_phase = hsel & hready & ((htrans == HTRANS_NONSEQ) | (htrans == HTRANS_SEQ));
    assign status_clear = wr_pend_q & (wr_addr_q == REFUSAL_STATUS_OFFSET)
                          & hwdata[EXCESS_FLAG_BIT];
    assign divisor = rate_divisor(setup_q[DIVIDER_MSB:DIVIDER_LSB]);

    // Threshold follows the short refusal limit bit.
    always_comb begin
        if (setup_q[SHORT_REFUSAL_BIT]) begin
            threshold = SHORT_REFUSAL_COUNT;
        end else begin
            threshold = LONG_REFUSAL_COUNT;
        end
    end

    // A refusal reaches the limit when the count including it meets the threshold.
    assign refusal_hit = refusal_detected & (sat_inc(refusal_cnt_q) >= threshold);

    // Bus next state: writes land in the data phase, reads are captured at the address phase.
    always_comb begin
        wr_pend_d = addr_phase & hwrite;
        wr_addr_d = wr_pend_d ? haddr : wr_addr_q;
        rdata_d = 32'h0000_0000;
        if (addr_phase & ~hwrite) begin
            if (haddr == SETUP_ONE_OFFSET) begin
                rdata_d = {24'h00_0000, setup_q};
            end else if (haddr == NODE_ID_OFFSET) begin
                rdata_d = {24'h00_0000, node_id_q};
            end else if (haddr == REFUSAL_STATUS_OFFSET) begin
                rdata_d = {16'h0000, refusal_cnt_q, 7'h00, excess_q};
            end else begin
                rdata_d = 32'h0000_0000;
            end
        end
    end

    // Bus registers; the slave never inserts wait states.
    // Read data falls back to zero after its data phase, so no stale value lingers.
    always_ff @(posedge hclk or negedge hresetn) begin
        if (!hresetn) begin
            wr_pend_q <= 1'b0;
            wr_addr_q <= 8'h00;
            rdata_q <= 32'h0000_0000;
        end else begin
            wr_pend_q <= wr_pend_d;
            wr_addr_q <= wr_addr_d;
            rdata_q <= rdata_d;
        end
    end

    // Software registers; the reserved bit is not stored so it always reads zero.
    always_comb begin
        setup_d = setup_q;
        node_id_d = node_id_q;
        if (wr_pend_q && (wr_addr_q == SETUP_ONE_OFFSET)) begin
            setup_d = hwdata[7:0] & SETUP_ONE_WRITABLE;
        end else if (wr_pend_q && (wr_addr_q == NODE_ID_OFFSET)) begin
            node_id_d = hwdata[7:0];
        end
    end

    // Reset leaves divider at 000, promiscuous and halved arbitration off.
    always_ff @(posedge hclk or negedge hresetn) begin
        if (!hresetn) begin
            setup_q <= SETUP_ONE_RESET;
            node_id_q <= NODE_ID_RESET;
        end else begin
            setup_q <= setup_d;
            node_id_q <= node_id_d;
        end
    end

    // Refusal counter and sticky flag; a refusal in the clearing cycle counts as 1, and sets the flag if the pre-clear count plus one meets the threshold.
    // Letting the set win means a refusal that lands on a clear is never lost.
    always_comb begin
        refusal_cnt_d = refusal_cnt_q;
        excess_d = excess_q;
        if (status_clear) begin
            refusal_cnt_d = refusal_detected ? 8'h01 : 8'h00;
            excess_d = 1'b0;
        end else if (refusal_detected) begin
            refusal_cnt_d = sat_inc(refusal_cnt_q);
        end
        if (refusal_hit) begin
            excess_d = 1'b1;
        end
    end

    // The count saturates so a long run of refusals cannot wrap below the threshold.
    always_ff @(posedge hclk or negedge hresetn) begin
        if (!hresetn) begin
            refusal_cnt_q <= 8'h00;
            excess_q <= 1'b0;
        end else begin
            refusal_cnt_q <= refusal_cnt_d;
            excess_q <= excess_d;
        end
    end

    // Pulse-one driver: open drain only pulls low, push-pull always drives.
    // In open drain a high level is left to the line's pull-up, never driven.
    always_comb begin
        pulse_out_d = pulse_one_level;
        pulse_oe_n_d = 1'b0;
        if (backplane_mode && !setup_q[PULSE_ONE_DRIVE_BIT]) begin
            pulse_out_d = 1'b0;
            pulse_oe_n_d = pulse_one_level;
        end
    end

    // Receive filter: acceptance may be promiscuous, acknowledgement never is.
    // A monitoring node can listen to all traffic without answering for other nodes.
    always_comb begin
        accept_d = rx_packet_valid
                   & (setup_q[PROMISCUOUS_BIT] | (rx_dest_id == node_id_q));
        ack_d = rx_packet_valid & (rx_dest_id == node_id_q);
    end

    // Data rate prescaler: one tick per divisor cycles of the base clock.
    // The bus clock stands in for the base clock; a new code applies at the next compare.
    always_comb begin
        rate_tick_d = 1'b0;
        rate_cnt_d = sat_inc(rate_cnt_q);
        if (sat_inc(rate_cnt_q) >= divisor) begin
            rate_cnt_d = 8'h00;
            rate_tick_d = 1'b1;
        end
    end

    // Arbitration enable toggles when halved, otherwise stays high.
    always_comb begin
        arb_en_d = 1'b1;
        if (setup_q[HALVED_ARB_BIT]) begin
            arb_en_d = ~arb_en_q;
        end
    end

    // Pulse-one registers; reset leaves the pin released.
    always_ff @(posedge hclk or negedge hresetn) begin
        if (!hresetn) begin
            pulse_out_q <= 1'b0;
            pulse_oe_n_q <= 1'b1;
        end else begin
            pulse_out_q <= pulse_out_d;
            pulse_oe_n_q <= pulse_oe_n_d;
        end
    end

    // Receive filter registers.
    always_ff @(posedge hclk or negedge hresetn) begin
        if (!hresetn) begin
            accept_q <= 1'b0;
            ack_q <= 1'b0;
        end else begin
            accept_q <= accept_d;
            ack_q <= ack_d;
        end
    end

    // Data rate prescaler registers.
    always_ff @(posedge hclk or negedge hresetn) begin
        if (!hresetn) begin
            rate_cnt_q <= 8'h00;
            rate_tick_q <= 1'b0;
        end else begin
            rate_cnt_q <= rate_cnt_d;
            rate_tick_q <= rate_tick_d;
        end
    end

    // Arbitration enable register; it resets high so arbitration starts undivided.
    always_ff @(posedge hclk or negedge hresetn) begin
        if (!hresetn) begin
            arb_en_q <= 1'b1;
        end else begin
            arb_en_q <= arb_en_d;
        end
    end

    // Ready and response: this slave never stalls and never errors, yet both still
    // come from flops so the bus sees no combinational path from the inputs.
    logic hreadyout_q, hreadyout_d;
    logic hresp_q, hresp_d;
    always_comb begin
        hreadyout_d = 1'b1;
        hresp_d = HRESP_OKAY;
    end

    // Ready and response registers.
    always_ff @(posedge hclk or negedge hresetn) begin
        if (!hresetn) begin
            hreadyout_q <= 1'b1;
            hresp_q <= HRESP_OKAY;
        end else begin
            hreadyout_q <= hreadyout_d;
            hresp_q <= hresp_d;
        end
    end

    // Output assignments, each straight from a flip-flop.
    assign hreadyout = hreadyout_q;
    assign hresp = hresp_q;
    assign hrdata = rdata_q;
    assign line_pulse_one_output = pulse_out_q;
    assign line_pulse_one_oe_n = pulse_oe_n_q;
    assign excess_refusal_flag = excess_q;
    assign rx_accept = accept_q;
    assign ack_send = ack_q;
    assign data_rate_tick = rate_tick_q;
    assign arb_clock_enable = arb_en_q;

endmodule : network_setup_config
`default_nettype wire

// ---- network_setup_pkg.sv ----
// Constants shared by the network setup register block.
`default_nettype none
package network_setup_pkg;
    // Byte offsets of the registers on the bus.
    localparam logic [7:0] SETUP_ONE_OFFSET = 8'h00;
    localparam logic [7:0] NODE_ID_OFFSET = 8'h04;
    localparam logic [7:0] REFUSAL_STATUS_OFFSET = 8'h08;
    // Field positions inside the setup register.
    localparam int PULSE_ONE_DRIVE_BIT = 7;
    localparam int SHORT_REFUSAL_BIT = 6;
    localparam int RESERVED_BIT = 5;
    localparam int PROMISCUOUS_BIT = 4;
    localparam int DIVIDER_LSB = 1;
    localparam int DIVIDER_MSB = 3;
    localparam int HALVED_ARB_BIT = 0;
    // Field positions inside the refusal status register.
    localparam int EXCESS_FLAG_BIT = 0;
    localparam int REFUSAL_COUNT_LSB = 8;
    // Reset values and the write mask of the setup register.
    localparam logic [7:0] SETUP_ONE_RESET = 8'h00;
    localparam logic [7:0] NODE_ID_RESET = 8'h00;
    localparam logic [7:0] SETUP_ONE_WRITABLE = 8'hDF;
    // Refusal thresholds for the short and the long limit, and the saturation value of the count.
    localparam logic [7:0] SHORT_REFUSAL_COUNT = 8'h04;
    localparam logic [7:0] LONG_REFUSAL_COUNT = 8'h80;
    localparam logic [7:0] REFUSAL_COUNT_MAX = 8'hFF;
    // AHB transfer type and response codes.
    localparam logic [1:0] HTRANS_NONSEQ = 2'h2;
    localparam logic [1:0] HTRANS_SEQ = 2'h3;
    localparam logic HRESP_OKAY = 1'h0;
endpackage : network_setup_pkg
`default_nettype wire

// ---- network_setup_sva.sv ----
// Port-level checks for the network setup register block.
`default_nettype none
module network_setup_sva
    import network_setup_pkg::*;
(
    // Clock and reset.
    input wire logic hclk,
    input wire logic hresetn,
    // Bus side.
    input wire logic hsel,
    input wire logic [7:0] haddr,
    input wire logic [1:0] htrans,
    input wire logic hwrite,
    input wire logic [31:0] hwdata,
    input wire logic hreadyout,
    input wire logic hresp,
    // Steered outputs and the inputs that steer them.
    input wire logic backplane_mode,
    input wire logic pulse_one_level,
    input wire logic line_pulse_one_output,
    input wire logic line_pulse_one_oe_n,
    input wire logic refusal_detected,
    input wire logic excess_refusal_flag,
    input wire logic rx_packet_valid,
    input wire logic rx_accept,
    input wire logic ack_send,
    input wire logic data_rate_tick,
    input wire logic arb_clock_enable
);
    timeunit 1ns;
    timeprecision 1ps;
    default clocking @(posedge hclk);
    endclocking
    default disable iff (!hresetn);

    // A status clear is an address phase followed by a data phase with bit 0 set.
    // A refusal in that data phase can win over the clear, so it is left out here.
    sequence clr_s;
        hsel && htrans == HTRANS_NONSEQ && hwrite && haddr == REFUSAL_STATUS_OFFSET
        ##1 hwdata[EXCESS_FLAG_BIT] && !refusal_detected;
    endsequence

    a_bus_okay: assert property (hresp == HRESP_OKAY && hreadyout)
        else $error("bus answer not ready and okay");
    a_flag_clear: assert property (clr_s |=> !excess_refusal_flag)
        else $error("flag survived a clear");
    a_flag_cause: assert property ($rose(excess_refusal_flag) |-> $past(refusal_detected))
        else $error("flag rose without a refusal");
    a_ack_match: assert property (ack_send |-> rx_accept && $past(rx_packet_valid))
        else $error("ack without accepted packet");
    a_accept_cause: assert property (rx_accept |-> $past(rx_packet_valid))
        else $error("accept without a packet");
    a_tick_space: assert property (data_rate_tick |=> !data_rate_tick [*7])
        else $error("rate ticks closer than eight");
    a_open_drain: assert property (line_pulse_one_oe_n |-> !line_pulse_one_output)
        else $error("released pin drives high");
    a_push_level: assert property ($past(hresetn) && !line_pulse_one_oe_n
        |-> line_pulse_one_output == $past(pulse_one_level))
        else $error("driven pin level wrong");
    a_plain_drive: assert property ($past(hresetn) && !$past(backplane_mode)
        |-> !line_pulse_one_oe_n)
        else $error("pin released outside backplane");
    a_arb_even: assert property (!arb_clock_enable |=> arb_clock_enable)
        else $error("arbitration enable low twice");
endmodule : network_setup_sva

bind network_setup_config network_setup_sva network_setup_sva_inst (
    .hclk(hclk),
    .hresetn(hresetn),
    .hsel(hsel),
    .haddr(haddr),
    .htrans(htrans),
    .hwrite(hwrite),
    .hwdata(hwdata),
    .hreadyout(hreadyout),
    .hresp(hresp),
    .backplane_mode(backplane_mode),
    .pulse_one_level(pulse_one_level),
    .line_pulse_one_output(line_pulse_one_output),
    .line_pulse_one_oe_n(line_pulse_one_oe_n),
    .refusal_detected(refusal_detected),
    .excess_refusal_flag(excess_refusal_flag),
    .rx_packet_valid(rx_packet_valid),
    .rx_accept(rx_accept),
    .ack_send(ack_send),
    .data_rate_tick(data_rate_tick),
    .arb_clock_enable(arb_clock_enable)
);
`default_nettype wire

// ---- tb.sv ----
// Self-checking bench for the network setup register block.
`default_nettype none
module tb
    import network_setup_pkg::*;
;
    timeunit 1ns;
    timeprecision 1ps;
    logic hclk, hresetn, hsel, hwrite, hready, hreadyout, hresp;
    logic [7:0] haddr, rx_dest_id;
    logic [1:0] htrans;
    logic [2:0] hsize;
    logic [31:0] hwdata, hrdata, rv;
    logic backplane_mode, pulse_one_level, line_pulse_one_output, line_pulse_one_oe_n;
    logic refusal_detected, excess_refusal_flag, rx_packet_valid, rx_accept, ack_send;
    logic data_rate_tick, arb_clock_enable;
    int err_total = 0;
    int checks_done = 0;

    // The single slave's ready is the bus ready.
    assign hready = hreadyout;

    network_setup_config network_setup_config_inst (
        .hclk(hclk),
        .hresetn(hresetn),
        .hsel(hsel),
        .haddr(haddr),
        .htrans(htrans),
        .hwrite(hwrite),
        .hsize(hsize),
        .hready(hready),
        .hwdata(hwdata),
        .hreadyout(hreadyout),
        .hresp(hresp),
        .hrdata(hrdata),
        .backplane_mode(backplane_mode),
        .pulse_one_level(pulse_one_level),
        .line_pulse_one_output(line_pulse_one_output),
        .line_pulse_one_oe_n(line_pulse_one_oe_n),
        .refusal_detected(refusal_detected),
        .excess_refusal_flag(excess_refusal_flag),
        .rx_packet_valid(rx_packet_valid),
        .rx_dest_id(rx_dest_id),
        .rx_accept(rx_accept),
        .ack_send(ack_send),
        .data_rate_tick(data_rate_tick),
        .arb_clock_enable(arb_clock_enable)
    );

    // Free-running 50 MHz clock.
    initial begin
        hclk = 1'b0;
        forever #10 hclk = ~hclk;
    end

    task automatic end_sim();
        $display("checks %0d mismatches %0d", checks_done, err_total);
        if (err_total == 0 && checks_done > 0) begin
            $display("verification passed");
        end else begin
            $display("verification failed");
        end
        $finish;
    endtask : end_sim

    task automatic chk(input string n, input logic [31:0] s, input logic [31:0] e);
        checks_done++;
        if (s !== e) begin
            err_total++;
            $display("Error %s expected %h seen %h", n, e, s);
        end
    endtask : chk

    // One single transfer; the watchdog cuts short a ready that never comes.
    task automatic bus(input logic w, input logic [7:0] a, input logic [31:0] d);
        @(posedge hclk);
        hsel <= 1'b1;
        haddr <= a;
        hwrite <= w;
        htrans <= HTRANS_NONSEQ;
        @(posedge hclk);
        while (hready !== 1'b1) @(posedge hclk);
        hsel <= 1'b0;
        htrans <= 2'h0;
        hwdata <= d;
        @(posedge hclk);
        while (hready !== 1'b1) @(posedge hclk);
        rv = hrdata;
    endtask : bus

    task automatic t_regs();
        bus(1'b0, SETUP_ONE_OFFSET, 32'h0);
        chk("setup reset", rv, 32'h0);
        bus(1'b1, 8'h0C, 32'hFFFFFFFF);
        bus(1'b0, 8'h0C, 32'h0);
        chk("unmapped", rv, 32'h0);
        // Every defined bit set, reserved bit 5 and the undefined divider codes left alone.
        bus(1'b1, SETUP_ONE_OFFSET, 32'h000000D9);
        bus(1'b0, SETUP_ONE_OFFSET, 32'h0);
        chk("setup readback", rv, 32'h000000D9);
        $display("test regs done");
    endtask : t_regs

    task automatic t_pulse(input logic pp);
        bus(1'b1, SETUP_ONE_OFFSET, {24'h0, pp, 7'h0});
        backplane_mode <= 1'b1;
        for (int l = 0; l < 2; l++) begin
            pulse_one_level <= l[0];
            repeat (2) @(posedge hclk);
            chk("pulse out", line_pulse_one_output, pp & l[0]);
            chk("pulse oe_n", line_pulse_one_oe_n, !pp & l[0]);
        end
        // Outside backplane mode the pin is always driven with the level.
        backplane_mode <= 1'b0;
        repeat (2) @(posedge hclk);
        chk("plain out", line_pulse_one_output, 32'h1);
        chk("plain oe_n", line_pulse_one_oe_n, 32'h0);
        $display("test pulse done");
    endtask : t_pulse

    // Sends n refusals; the flag must wait for the last one.
    task automatic t_refuse(input logic s, input int n);
        bus(1'b1, SETUP_ONE_OFFSET, {25'h0, s, 6'h0});
        bus(1'b1, REFUSAL_STATUS_OFFSET, 32'h1);
        for (int i = 0; i < n; i++) begin
            @(posedge hclk);
            refusal_detected <= 1'b1;
            @(posedge hclk);
            refusal_detected <= 1'b0;
            repeat (2) @(posedge hclk);
            chk("flag", excess_refusal_flag, i == n - 1);
        end
        bus(1'b0, REFUSAL_STATUS_OFFSET, 32'h0);
        chk("status", rv, {16'h0, n[7:0], 8'h01});
        bus(1'b1, REFUSAL_STATUS_OFFSET, 32'h1);
        bus(1'b0, REFUSAL_STATUS_OFFSET, 32'h0);
        chk("status clear", rv, 32'h0);
        $display("test refusal done");
    endtask : t_refuse

    task automatic t_rx(input logic [7:0] id, input logic a, input logic k);
        @(posedge hclk);
        rx_packet_valid <= 1'b1;
        rx_dest_id <= id;
        @(posedge hclk);
        rx_packet_valid <= 1'b0;
        @(posedge hclk);
        chk("accept", rx_accept, a);
        chk("ack", ack_send, k);
        $display("test rx done");
    endtask : t_rx

    // Measures the third tick gap so a code change has settled.
    task automatic t_rate(input logic [2:0] code);
        int c;
        // No clock multiplier is modelled, so every defined code is allowed here.
        bus(1'b1, SETUP_ONE_OFFSET, {28'h0, code, 1'b0});
        repeat (3) begin
            c = 1;
            @(posedge hclk);
            while (data_rate_tick !== 1'b1 && c < 300) begin
                @(posedge hclk);
                c++;
            end
        end
        chk("tick gap", c, 32'h8 << code);
        $display("test rate done");
    endtask : t_rate

    task automatic t_arb(input logic h);
        logic a;
        // Without a multiplied clock either arbitration setting is allowed.
        bus(1'b1, SETUP_ONE_OFFSET, {31'h0, h});
        @(posedge hclk);
        a = arb_clock_enable;
        @(posedge hclk);
        chk("arb", {a, arb_clock_enable}, h ? {a, !a} : 2'h3);
        $display("test arb done");
    endtask : t_arb

    // Watchdog well beyond the longest expected run.
    initial begin
        repeat (20000) @(posedge hclk);
        err_total++;
        end_sim();
    end

    // Main sequence.
    initial begin
        {hresetn, hsel, hwrite, backplane_mode, pulse_one_level} = 5'h0;
        {refusal_detected, rx_packet_valid} = 2'h0;
        {haddr, rx_dest_id, htrans, hwdata} = 50'h0;
        hsize = 3'h2;
        repeat (6) @(posedge hclk);
        hresetn <= 1'b1;
        t_regs();
        t_arb(1'b0);
        t_pulse(1'b0);
        t_pulse(1'b1);
        t_refuse(1'b1, 4);
        t_refuse(1'b0, 128);
        bus(1'b1, NODE_ID_OFFSET, 32'h12);
        bus(1'b1, SETUP_ONE_OFFSET, 32'h10);
        t_rx(8'h34, 1'b1, 1'b0);
        t_rx(8'h12, 1'b1, 1'b1);
        bus(1'b1, SETUP_ONE_OFFSET, 32'h0);
        t_rx(8'h34, 1'b0, 1'b0);
        for (int i = 0; i < 5; i++) t_rate(i[2:0]);
        t_arb(1'b1);
        end_sim();
    end
endmodule : tb
`default_nettype wire
